/* rtl/dsas_pkg.sv */
package dsas_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_STAT  = 8'h08;
    localparam logic [7:0] OFS_MASK  = 8'h0C;
    localparam logic [7:0] OFS_RES   = 8'h40;
    // Result slots: first converter 0..9, second 10..33
    localparam int          NRES      = 34;
    localparam logic [5:0]  RES1_BASE = 6'h0A;
    // Control register fields
    localparam int CTL_DIV   = 0;   // 2 bits, divide by value+1
    localparam int CTL_RES10 = 2;
    localparam int CTL_SH    = 3;
    localparam int CTL_MODE  = 4;   // 3 bits
    localparam int CTL_TRIG  = 7;   // 2 bits
    localparam int CTL_HWSRC = 9;
    localparam int CTL_GRP   = 10;  // 2 bits
    localparam int CTL_CH0   = 12;  // 4 bits
    localparam int CTL_CH1   = 16;  // 3 bits
    localparam int CTL_W     = 19;
    localparam logic [18:0] CTRL_RST = 19'h00000;
    // Start register fields
    localparam int ST_GO0  = 0;
    localparam int ST_GO1  = 1;
    localparam int ST_PAIR = 2;
    // Conversion lengths in conversion-clock cycles
    localparam logic [5:0] CYC_8_NOSH  = 6'h31;
    localparam logic [5:0] CYC_10_NOSH = 6'h3B;
    localparam logic [5:0] CYC_8_SH    = 6'h1C;
    localparam logic [5:0] CYC_10_SH   = 6'h21;
    // Operating modes
    localparam logic [2:0] MD_ONE = 3'h0;
    localparam logic [2:0] MD_REP = 3'h1;
    localparam logic [2:0] MD_SWP = 3'h2;
    localparam logic [2:0] MD_RS0 = 3'h3;
    localparam logic [2:0] MD_RS1 = 3'h4;
    // Start sources
    localparam logic [1:0] TRG_SW  = 2'h0;
    localparam logic [1:0] TRG_EXT = 2'h1;
    localparam logic [1:0] TRG_HW  = 2'h2;
    // Converter sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMP = 3'b010,
        ST_CONV = 3'b100
    } dsas_st_e;
endpackage : dsas_pkg

/* rtl/dsas_top.sv */
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Two 10-bit SAR converters, each coupled
// - Both convert concurrently, independent, same method
// - Result lands in selected pin's slot
// - Conversion clock is source divided 1-4
// - Resolution selectable, 8 or 10 bits
// - Five modes: one-shot, repeat, sweeps
// - Software start bit begins conversion
// - Paired start bit starts both together
// - External falling edge starts when armed
// - External re-trigger restarts conversion
// - Hardware interrupt starts when armed, retriggerable
// - Motor timer reload request is hardware source
// - Intelligent I/O request per converter source
// - No sample-hold: 49 or 59 cycles
// - Sample-hold: 28 or 33 cycles
// - First fixed group, second selects group
// - Extended inputs only on first converter
module dsas_top
    import dsas_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq,
    input  wire logic        i_external_trigger_pin,
    input  wire logic        i_motor_timer_reload_irq,
    input  wire logic        i_iio_g2_ch1_irq,
    input  wire logic        i_iio_g3_ch1_irq,
    input  wire logic        i_cmp0,
    input  wire logic        i_cmp1,
    output logic      [9:0]  o_dac0,
    output logic      [9:0]  o_dac1,
    output logic      [3:0]  o_mux0,
    output logic      [4:0]  o_mux1,
    output logic             o_samp0,
    output logic             o_samp1
);

    // Single-bit mask at a bit position
    function automatic logic [9:0] bit_of(input logic [3:0] k);
        bit_of = 10'h001 << k;
    endfunction : bit_of

    // All state freezes while i_ce is low
    // Bus and register state
    logic [CTL_W-1:0] ctrl_ff;        // Configuration
    logic [1:0]       stat_ff;        // Sticky completion flags
    logic [1:0]       mask_ff;        // Interrupt enables
    logic             ack_ff;         // Second cycle of a bus request
    logic [31:0]      rdata_ff;       // Captured read data
    logic [9:0]       res_ff [NRES];  // Per-pin result slots
    logic [1:0]       div_ff;         // Conversion clock divider
    logic             trg_d_ff;       // Previous trigger pin level

    // Field decode
    // Read straight from the control word
    // Mid-conversion changes are not guarded
    wire [1:0] div_sel = ctrl_ff[CTL_DIV +: 2];
    wire       res10   = ctrl_ff[CTL_RES10];
    wire       sh_on   = ctrl_ff[CTL_SH];
    wire [2:0] mode    = ctrl_ff[CTL_MODE +: 3];
    wire [1:0] trig    = ctrl_ff[CTL_TRIG +: 2];
    wire       hw_iio  = ctrl_ff[CTL_HWSRC];
    wire [1:0] grp_raw = ctrl_ff[CTL_GRP +: 2];
    wire [1:0] grp     = (grp_raw == 2'h3) ? 2'h2 : grp_raw;  // Spare code aliases third group

    // Bus request handshake: one wait cycle, then accept
    // Wait cycle captures read data
    wire       req     = i_avs_read | i_avs_write;
    wire       acc     = req & ack_ff;
    wire       wr_acc  = acc & i_avs_write;
    wire       rd_acc  = acc & i_avs_read;
    wire [5:0] res_idx = 6'(i_avs_address[7:2] - OFS_RES[7:2]);
    wire       hit_res = (i_avs_address >= OFS_RES) && (res_idx < 6'(NRES))
                         && (i_avs_address[1:0] == 2'h0);
    wire       wr_ctrl  = wr_acc && (i_avs_address == OFS_CTRL);
    wire       wr_start = wr_acc && (i_avs_address == OFS_START);
    wire       wr_mask  = wr_acc && (i_avs_address == OFS_MASK);
    wire       rd_stat  = rd_acc && (i_avs_address == OFS_STAT);
    // Combinational, so it rises with the request
    assign o_avs_waitrequest = req & ~ack_ff;
    assign o_avs_readdata    = rdata_ff;

    // Shared conversion clock as an enable, divide by div_sel+1
    // An enable keeps one clock domain
    wire tick = (div_ff == div_sel);

    // Per-pin length follows resolution and sample-hold choice
    wire [5:0] tot_len = sh_on ? (res10 ? CYC_10_SH : CYC_8_SH)
                               : (res10 ? CYC_10_NOSH : CYC_8_NOSH);
    // First trial bit for the resolution
    wire [3:0] top_bit = res10 ? 4'h9 : 4'h7;
    // Last sample count; bit steps fill the rest exactly
    wire [5:0] smp_len = 6'(tot_len - {2'h0, top_bit} - 6'h02);

    // External pin falls; pin is taken as synchronous
    // History resets high: no edge at reset
    wire ext_fall = trg_d_ff & ~i_external_trigger_pin;
    wire sw_mode  = (trig == TRG_SW);
    // Paired bit of a start write
    wire pair_wr  = wr_start & i_avs_writedata[ST_PAIR];

    // Per-converter views
    // Flattened for the shared logic
    logic [1:0] go_w;
    logic [1:0] done_w;
    logic [1:0] begin_w;
    logic [5:0] slot_w [2];
    logic [9:0] val_w  [2];

    for (genvar gi = 0; gi < 2; gi++)
    begin : g_cv
        dsas_st_e   st_ff;   // Sequencer state
        logic [5:0] cyc_ff;  // Conversion-clock count within a pin
        logic [9:0] sar_ff;  // Trial code driven to the DAC
        logic [3:0] bit_ff;  // Bit under test
        logic [3:0] ch_ff;   // Channel in conversion
        logic       go_ff;   // Conversion start bit

        // This converter's comparator
        wire       cmp    = (gi == 0) ? i_cmp0 : i_cmp1;
        wire [3:0] sel    = (gi == 0) ? ctrl_ff[CTL_CH0 +: 4] : {1'b0, ctrl_ff[CTL_CH1 +: 3]};
        // Single-pin modes reuse the selection
        wire       single = (mode == MD_ONE) || (mode == MD_REP);
        wire [3:0] top    = (mode == MD_RS1) ? {1'b0, sel[2:0]} : 4'h7;
        wire       last   = single || (ch_ff == top);
        wire       stop   = last && ((mode == MD_ONE) || (mode == MD_SWP));
        wire [3:0] first  = single ? sel : 4'h0;
        wire [3:0] nxt_ch = single ? sel : (last ? 4'h0 : 4'(ch_ff + 4'h1));
        // Own bit or paired bit starts it
        wire       go_wr  = wr_start & (i_avs_writedata[gi] | i_avs_writedata[ST_PAIR]);
        wire       halt   = wr_start & ~i_avs_writedata[gi] & ~i_avs_writedata[ST_PAIR];
        // Hardware source: motor timer, or the converter's own I/O channel
        wire       hw_evt = hw_iio ? ((gi == 0) ? i_iio_g2_ch1_irq : i_iio_g3_ch1_irq)
                                   : i_motor_timer_reload_irq;
        wire       trg_ok = ((trig == TRG_EXT) && ext_fall)
                            || ((trig == TRG_HW) && hw_evt);
        // Software mode starts on the write; other modes need an armed bit
        wire       beg    = sw_mode ? go_wr : (go_ff & trg_ok & ~halt);
        // Tick that resolves the last bit
        wire       fin    = (st_ff == ST_CONV) && tick && (bit_ff == 4'h0);
        // Trial bit kept if input is at or above
        wire [9:0] keep   = cmp ? sar_ff : (sar_ff & ~bit_of(bit_ff));

        // Exports to the shared logic
        assign go_w[gi]    = go_ff;
        assign done_w[gi]  = fin;
        assign begin_w[gi] = beg;
        assign val_w[gi]   = keep;
        // First converter: own group plus the two extended pins only
        assign slot_w[gi]  = (gi == 0) ? ((ch_ff < 4'hA) ? {2'h0, ch_ff} : 6'h09)
                                       : 6'(RES1_BASE + {grp, 3'h0} + {3'h0, ch_ff[2:0]});

        // Trigger modes keep it armed
        // Start bit: set by writes, dropped when a software sequence ends
        always_ff @(posedge i_sys_clk)
        begin
            if (!i_nrst)
                go_ff <= 1'b0;
            else if (i_ce)
            begin
                if (wr_start)
                    go_ff <= go_wr;
                else if (fin && stop && sw_mode)
                    go_ff <= 1'b0;
            end
        end

        // Halt wins, so a stop beats a trigger
        // Sample, then one bit per conversion clock; both run side by side
        always_ff @(posedge i_sys_clk)
        begin
            if (!i_nrst)
            begin
                st_ff  <= ST_IDLE;
                cyc_ff <= 6'h00;
                sar_ff <= 10'h000;
                bit_ff <= 4'h0;
                ch_ff  <= 4'h0;
            end
            else if (i_ce)
            begin
                if (halt)
                    st_ff <= ST_IDLE;  // Writing zero abandons the pin
                else if (beg)
                begin
                    // Restart from scratch, even mid-conversion
                    st_ff  <= ST_SAMP;
                    cyc_ff <= 6'h00;
                    sar_ff <= 10'h000;
                    ch_ff  <= first;
                end
                else if (tick)
                begin
                    unique case (st_ff)
                        ST_IDLE: ;
                        ST_SAMP:
                        begin
                            cyc_ff <= 6'(cyc_ff + 6'h01);
                            // Sampling over: load top trial bit
                            if (cyc_ff == smp_len)
                            begin
                                st_ff  <= ST_CONV;
                                bit_ff <= top_bit;
                                sar_ff <= bit_of(top_bit);
                            end
                        end
                        ST_CONV:
                        begin
                            cyc_ff <= 6'(cyc_ff + 6'h01);
                            if (bit_ff == 4'h0)
                            begin
                                // Pin finished: next pin or stop
                                st_ff  <= stop ? ST_IDLE : ST_SAMP;
                                cyc_ff <= 6'h00;
                                sar_ff <= 10'h000;
                                ch_ff  <= nxt_ch;
                            end
                            else
                            begin
                                sar_ff <= keep | bit_of(4'(bit_ff - 4'h1));
                                bit_ff <= 4'(bit_ff - 4'h1);
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Eight-bit codes sit in the top bits
    // Analog side drives
    assign o_dac0  = res10 ? g_cv[0].sar_ff : {g_cv[0].sar_ff[7:0], 2'h0};
    assign o_dac1  = res10 ? g_cv[1].sar_ff : {g_cv[1].sar_ff[7:0], 2'h0};
    assign o_mux0  = g_cv[0].ch_ff;
    assign o_mux1  = 5'({grp, 3'h0} + {2'h0, g_cv[1].ch_ff[2:0]});
    assign o_samp0 = (g_cv[0].st_ff == ST_SAMP);
    assign o_samp1 = (g_cv[1].st_ff == ST_SAMP);
    assign o_irq   = |(stat_ff & mask_ff);

    // Read data selection
    // Unmapped addresses read as zero
    wire [31:0] rd_val =
        (i_avs_address == OFS_CTRL)  ? 32'(ctrl_ff) :
        (i_avs_address == OFS_START) ? {30'h0, go_w} :
        (i_avs_address == OFS_STAT)  ? {30'h0, stat_ff} :
        (i_avs_address == OFS_MASK)  ? {30'h0, mask_ff} :
        hit_res                      ? {22'h0, res_ff[res_idx]} : 32'h0;

    // Bus slave registers
    // Read data held until the next request
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
            ctrl_ff  <= CTRL_RST;
            mask_ff  <= 2'h0;
        end
        else if (i_ce)
        begin
            ack_ff <= req & ~ack_ff;
            if (req & ~ack_ff)
                rdata_ff <= rd_val;
            if (wr_ctrl)
                ctrl_ff <= i_avs_writedata[CTL_W-1:0];
            if (wr_mask)
                mask_ff <= i_avs_writedata[1:0];
        end
    end

    // Status: completion wins over a clearing read
    // Only bits already returned are cleared,
    // so a done in the wait cycle is kept
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
            stat_ff <= 2'h0;
        else if (i_ce)
            stat_ff <= (rd_stat ? (stat_ff & ~rdata_ff[1:0]) : stat_ff) | done_w;
    end

    // Divider and trigger pin history
    // Free-running: first tick may come early
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            div_ff   <= 2'h0;
            trg_d_ff <= 1'b1;
        end
        else if (i_ce)
        begin
            div_ff   <= tick ? 2'h0 : 2'(div_ff + 2'h1);
            trg_d_ff <= i_external_trigger_pin;
        end
    end

    // Result slots, written by either converter on completion
    // Slot ranges never overlap
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            for (int k = 0; k < NRES; k++)
                res_ff[k] <= 10'h000;
        end
        else if (i_ce)
        begin
            for (int c = 0; c < 2; c++)
                if (done_w[c])
                    res_ff[slot_w[c]] <= res10 ? val_w[c] : {2'h0, val_w[c][7:0]};
        end
    end

    // Checks
    // They watch design state only
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    sw_start_a: assert property (
        (sw_mode && begin_w[0] && i_ce && !pair_wr)
        |=> (g_cv[0].st_ff == ST_SAMP) && (g_cv[0].cyc_ff == 6'h00))
        else $error("software start did not begin first converter");
    pair_start_a: assert property (
        (sw_mode && pair_wr && i_ce)
        |=> (g_cv[0].st_ff == ST_SAMP) && (g_cv[1].st_ff == ST_SAMP))
        else $error("paired start did not begin both converters");
    ext_arm_a: assert property (
        (trig == TRG_EXT && !go_w[0] && !wr_start && i_ce && g_cv[0].st_ff == ST_IDLE)
        |=> (g_cv[0].st_ff == ST_IDLE))
        else $error("unarmed converter started");
    ext_retrig_a: assert property (
        (trig == TRG_EXT && go_w[0] && ext_fall && !wr_start && i_ce)
        |=> (g_cv[0].st_ff == ST_SAMP) && (g_cv[0].cyc_ff == 6'h00))
        else $error("external edge did not restart conversion");
    iio_trig_a: assert property (
        (trig == TRG_HW && hw_iio && go_w[1] && i_iio_g3_ch1_irq && !wr_start && i_ce)
        |=> (g_cv[1].st_ff == ST_SAMP))
        else $error("I/O request did not start second converter");
    pin_len_a: assert property (
        done_w[0] |-> (g_cv[0].cyc_ff == 6'(tot_len - 6'h01)))
        else $error("pin conversion length wrong");
    res_store_a: assert property (
        (done_w[1] && i_ce) |=> (res_ff[$past(slot_w[1])] == $past(res10 ? val_w[1]
                                 : {2'h0, val_w[1][7:0]})))
        else $error("result not stored in pin slot");
    done_irq_a: assert property (
        (done_w[0] && mask_ff[0] && i_ce) |=> o_irq && stat_ff[0])
        else $error("completion did not raise interrupt");
    // A control write may change the ratio inside the window
    div_tick_a: assert property (
        (tick && div_sel == 2'h3 && i_ce && !wr_ctrl)
        |=> !tick ##1 (!tick || div_sel != 2'h3) ##1 (!tick || div_sel != 2'h3))
        else $error("divide by four ticks too often");

    // Main scenarios
    cover property (sw_mode && mode == MD_ONE && done_w[0]);
    cover property (pair_wr && sw_mode);
    cover property (trig == TRG_EXT && ext_fall && go_w[0] && g_cv[0].st_ff == ST_CONV);
    cover property (done_w[1] && mode == MD_RS1);

endmodule : dsas_top

/* verif/dsas_analog_model.sv */
`timescale 1ns/1ps
// Analog pins behind both converters, seen through each converter's comparator
module dsas_analog_model
    import dsas_pkg::*;
(
    input  wire logic [9:0] i_dac0,   // Trial code, first converter
    input  wire logic [9:0] i_dac1,   // Trial code, second converter
    input  wire logic [3:0] i_mux0,   // Selected pin, first converter
    input  wire logic [4:0] i_mux1,   // Selected pin, second converter
    output logic            o_cmp0,   // High while pin level >= trial code
    output logic            o_cmp1    // Same for the second converter
);
    // Every pin sits at its own level, so a wrong selection shows in the result
    logic [9:0] lvl0;                 // Level of pin on first converter
    logic [9:0] lvl1;                 // Level of pin on second converter
    assign lvl0   = 10'(i_mux0) * 10'h025 + 10'h00B;
    assign lvl1   = 10'(i_mux1) * 10'h029 + 10'h009;
    // Ideal comparator, no offset: the bench predicts codes exactly
    assign o_cmp0 = (lvl0 >= i_dac0);
    assign o_cmp1 = (lvl1 >= i_dac1);
endmodule : dsas_analog_model

/* verif/dsas_top_tb.sv */
`timescale 1ns/1ps
// Register-level bench with pin triggers; comparator model on the analog side
module dsas_top_tb
    import dsas_pkg::*;
;
    logic        sys_clk = 1'b0;      // 125 MHz
    logic        nrst    = 1'b0;      // Held low six cycles
    logic [7:0]  addr    = 8'h00;     // Bus address
    logic        rd      = 1'b0;      // Bus read
    logic        wr      = 1'b0;      // Bus write
    logic [31:0] wdata   = 32'h0;     // Bus write data
    logic        ext_pin = 1'b1;      // External trigger, idles high
    logic        mtr     = 1'b0;      // Motor timer request
    logic        g2      = 1'b0;      // I/O group 2 channel 1 request
    logic        g3      = 1'b0;      // I/O group 3 channel 1 request
    logic [31:0] rdata;               // Bus read data
    logic        wait_req;            // Bus waitrequest
    logic        irq;                 // Level interrupt
    logic        cmp0, cmp1, samp0, samp1;
    logic [9:0]  dac0, dac1;
    logic [3:0]  mux0;
    logic [4:0]  mux1;
    int          num_errors = 0;      // Mismatches
    int          compares   = 0;      // Comparisons made
    int          cyc        = 0;      // Timeout counter
    int          n;                   // Cycles waited for interrupt
    logic [31:0] d;                   // Last read value

    dsas_top uut (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_ce(1'b1), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .o_irq(irq), .i_external_trigger_pin(ext_pin),
        .i_motor_timer_reload_irq(mtr), .i_iio_g2_ch1_irq(g2), .i_iio_g3_ch1_irq(g3),
        .i_cmp0(cmp0), .i_cmp1(cmp1), .o_dac0(dac0), .o_dac1(dac1), .o_mux0(mux0),
        .o_mux1(mux1), .o_samp0(samp0), .o_samp1(samp1));
    dsas_analog_model pins (.i_dac0(dac0), .i_dac1(dac1), .i_mux0(mux0), .i_mux1(mux1),
        .o_cmp0(cmp0), .o_cmp1(cmp1));

    always #4 sys_clk = ~sys_clk;

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            num_errors++;
            test_done();
        end
    end

    // Closing report, the only place the run ends
    task automatic test_done;
        $display("Counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Window check on the interrupt wait, since start-up latency is a few cycles
    task automatic win(input string nm, input int lo, input int hi);
        compares++;
        if (n < lo || n > hi)
        begin
            num_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
        end
    endtask : win

    // One Avalon transfer; waitrequest and read data taken at one rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge sys_clk);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= v;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (wait_req !== 1'b0 && k < 50);
        d = rdata;
        if (k >= 50)
            chk("waitrequest", 32'h0, 32'h1);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, d);
    endtask : rdchk

    // Waits for the interrupt, at most m cycles; n tells how long
    task automatic wait_irq(input int m);
        n = 0;
        while (irq !== 1'b1 && n < m)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_irq

    // One-cycle request: 0 motor timer, 1 group 2, 2 group 3, 3 external falling edge
    task automatic pulse(input int s);
        @(posedge sys_clk);
        mtr     <= (s == 0);
        g2      <= (s == 1);
        g3      <= (s == 2);
        ext_pin <= (s != 3);
        @(posedge sys_clk);
        {mtr, g2, g3, ext_pin} <= 4'h1;
    endtask : pulse

    function automatic logic [31:0] mk(input int dv, r, sh, md, tr, src, grp, c0, c1);
        mk = 32'(dv) | (32'(r) << CTL_RES10) | (32'(sh) << CTL_SH) | (32'(md) << CTL_MODE)
           | (32'(tr) << CTL_TRIG) | (32'(src) << CTL_HWSRC) | (32'(grp) << CTL_GRP)
           | (32'(c0) << CTL_CH0) | (32'(c1) << CTL_CH1);
    endfunction : mk

    function automatic int tot(input int r, input int sh);
        tot = sh ? (r ? CYC_10_SH : CYC_8_SH) : (r ? CYC_10_NOSH : CYC_8_NOSH);
    endfunction : tot

    // Expected code: pin level, cut to the upper eight bits in 8-bit mode
    function automatic logic [31:0] res(input int lvl, input int r);
        res = r ? 32'(lvl) : 32'(lvl >> 2);
    endfunction : res

    function automatic logic [7:0] slot(input int k);
        slot = OFS_RES + 8'(4 * k);
    endfunction : slot

    initial
    begin
        static int dv[4] = '{0, 1, 2, 3};
        static int rs[4] = '{0, 1, 0, 1};
        static int sh[4] = '{0, 0, 1, 1};
        static int ch[4] = '{3, 9, 0, 8};
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        rdchk(OFS_CTRL, 32'(CTRL_RST), "ctrl reset");
        rdchk(OFS_STAT, 32'h0, "status reset");
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        rdchk(8'h10, 32'h0, "unmapped");
        chk("irq reset", 32'h0, 32'(irq));
        chk("samp idle", 32'h0, 32'({samp1, samp0}));
        $display("test reset done");
        // Divider, resolution and sample-hold each change the conversion length
        bus(1'b1, OFS_MASK, 32'h3);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, OFS_CTRL, mk(dv[i], rs[i], sh[i], 0, 0, 0, 0, ch[i], 0));
            rdchk(OFS_CTRL, mk(dv[i], rs[i], sh[i], 0, 0, 0, 0, ch[i], 0), "ctrl");
            bus(1'b1, OFS_START, 32'h1);
            wait_irq(700);
            win("latency", tot(rs[i], sh[i]) * (dv[i] + 1) - dv[i] + 1,
                tot(rs[i], sh[i]) * (dv[i] + 1) + 1);
            rdchk(OFS_STAT, 32'h1, "status done");
            rdchk(OFS_STAT, 32'h0, "status cleared");
            rdchk(slot(ch[i]), res(ch[i] * 37 + 11, rs[i]), "result");
            chk("irq low", 32'h0, 32'(irq));
        end
        // Masked completion: status set, interrupt stays low
        bus(1'b1, OFS_MASK, 32'h0);
        bus(1'b1, OFS_START, 32'h1);
        repeat (200) @(negedge sys_clk);
        chk("irq masked", 32'h0, 32'(irq));
        rdchk(OFS_STAT, 32'h1, "status masked");
        bus(1'b1, OFS_MASK, 32'h3);
        $display("test clocking done");
        // Paired start across all group codes, spare code 3 aliasing the third
        for (int g = 0; g < 4; g++)
        begin
            bus(1'b1, OFS_CTRL, mk(0, 1, 0, 0, 0, 0, g, 1, g + 4));
            bus(1'b1, OFS_START, 32'h4);
            @(negedge sys_clk);
            chk("both sampling", 32'h3, 32'({samp1, samp0}));
            wait_irq(200);
            repeat (2) @(negedge sys_clk);
            rdchk(OFS_STAT, 32'h3, "paired status");
            rdchk(slot(RES1_BASE + 8 * (g > 2 ? 2 : g) + g + 4),
                  res((8 * (g > 2 ? 2 : g) + g + 4) * 41 + 9, 1), "res1");
            rdchk(slot(1), res(48, 1), "res0");
        end
        $display("test paired done");
        // All five modes: one-shot and single sweep stop, the rest keep going
        for (int m = 0; m < 5; m++)
        begin
            bus(1'b1, OFS_CTRL, mk(0, m % 2, 1, m, 0, 0, 0, 7, 0));
            bus(1'b1, OFS_START, 32'h1);
            wait_irq(400);
            chk("mode irq", 32'h1, 32'(irq));
            repeat (300) @(negedge sys_clk);
            rdchk(OFS_STAT, 32'h1, "mode status");
            rdchk(slot(7), res(7 * 37 + 11, m % 2), "mode pin 7");
            if (m >= 2)
                rdchk(slot(0), res(11, m % 2), "sweep pin 0");
            wait_irq(400);
            chk("mode repeats", 32'(m == 1 || m > 2), 32'(irq));
            bus(1'b1, OFS_START, 32'h0);
            repeat (300) @(negedge sys_clk);
            bus(1'b1, 8'h08, 32'h0);
            bus(1'b0, OFS_STAT, 32'h0);
        end
        $display("test modes done");
        // External trigger: ignored unarmed, accepted armed, restarts on a later edge
        bus(1'b1, OFS_CTRL, mk(0, 0, 0, 0, 1, 0, 0, 5, 0));
        pulse(3);
        wait_irq(120);
        chk("ext unarmed", 32'h0, 32'(irq));
        bus(1'b1, OFS_START, 32'h1);
        pulse(3);
        wait_irq(120);
        win("ext latency", 46, 58);
        rdchk(slot(5), res(5 * 37 + 11, 0), "ext result");
        bus(1'b0, OFS_STAT, 32'h0);
        pulse(3);
        repeat (20) @(negedge sys_clk);
        pulse(3);
        wait_irq(120);
        win("ext restart", 46, 58);
        bus(1'b0, OFS_STAT, 32'h0);
        $display("test external done");
        // Hardware sources: motor timer, then per-converter I/O channels
        bus(1'b1, OFS_CTRL, mk(0, 0, 0, 0, 2, 0, 0, 2, 0));
        bus(1'b1, OFS_START, 32'h1);
        pulse(0);
        wait_irq(120);
        rdchk(OFS_STAT, 32'h1, "motor timer");
        rdchk(slot(2), res(2 * 37 + 11, 0), "motor result");
        bus(1'b1, OFS_CTRL, mk(0, 0, 0, 0, 2, 1, 0, 2, 0));
        bus(1'b1, OFS_START, 32'h3);
        pulse(2);
        wait_irq(120);
        repeat (4) @(negedge sys_clk);
        rdchk(OFS_STAT, 32'h2, "group 3");
        pulse(1);
        wait_irq(120);
        repeat (4) @(negedge sys_clk);
        rdchk(OFS_STAT, 32'h1, "group 2");
        bus(1'b1, OFS_START, 32'h0);
        $display("test hardware done");
        test_done();
    end
endmodule : dsas_top_tb
